// >>> rtl/rre_pkg.sv
package rre_pkg;

    // Width of the program counter and of a stack entry.
    localparam int unsigned PC_W = 11;
    // Width of one data byte.
    localparam int unsigned DATA_W = 8;
    // Width of a data-memory register address, 0 to 127.
    localparam int unsigned ADDR_W = 7;
    // Instruction cycles taken by a return and by a rotate.
    localparam int unsigned RETURN_CYCLES = 2;
    localparam int unsigned ROTATE_CYCLES = 1;
    // Destination select values of a rotate.
    localparam logic DEST_ACCUMULATOR = 1'h0;
    localparam logic DEST_REGISTER = 1'h1;
    // Bit position of the bit that leaves on each rotate.
    localparam int unsigned MSB_POS = 7;
    localparam int unsigned LSB_POS = 0;

    // Instruction codes handed over by the decoder.
    typedef enum logic [2:0] {
        op_none = 3'h0,
        op_subroutine_return = 3'h1,
        op_return_with_literal = 3'h2,
        op_rotate_left_carry = 3'h3,
        op_rotate_right_carry = 3'h4
    } rre_op_e;

    // Sequencer states, one-hot.
    typedef enum logic [1:0] {
        st_idle = 2'h1,
        st_return = 2'h2
    } rre_state_e;

    // One decoded instruction offered for execution.
    typedef struct packed {
        logic valid;
        rre_op_e op;
        logic [DATA_W-1:0] imm;
        logic [ADDR_W-1:0] addr;
        logic dest;
    } rre_issue_s;

    // Values read from the rest of the core.
    typedef struct packed {
        logic [DATA_W-1:0] reg_data;
        logic carry;
        logic [PC_W-1:0] stack_top;
    } rre_core_s;

    // Write strobes and data sent back into the core.
    typedef struct packed {
        logic accumulator_we;
        logic [DATA_W-1:0] accumulator_data;
        logic reg_we;
        logic [ADDR_W-1:0] reg_addr;
        logic [DATA_W-1:0] reg_data;
        logic pc_load;
        logic [PC_W-1:0] pc_value;
        logic stack_pop;
        logic carry_we;
        logic carry_value;
        logic busy;
    } rre_result_s;

    // Complete state of the execution block.
    typedef struct packed {
        rre_state_e state;
        logic literal;
        logic [DATA_W-1:0] imm;
        rre_result_s res;
    } rre_regs_s;

    // Value of all state after reset.
    localparam rre_regs_s REGS_RESET = '{state: st_idle, literal: 1'h0,
                                         imm: 8'h00, res: '0};

endpackage : rre_pkg

// >>> rtl/rre_exec.sv
`timescale 1ns/1ps
`default_nettype none

// Executes the return and rotate-through-carry instructions.
module rre_exec #(
    parameter int unsigned PC_WIDTH = 11  // Program counter width.
) (
    input wire logic clk_sys_in,  // Core clock, 25 MHz.
    input wire logic sys_rst_in,  // Asynchronous reset, active high.
    input wire logic clk_en_in,  // Freezes all state while low.
    input wire rre_pkg::rre_issue_s issue_in,  // Decoded instruction.
    input wire rre_pkg::rre_core_s core_in,  // Operands from the core.
    output var rre_pkg::rre_result_s result_out  // Registered writes.
);

    // The result fields are sized by the package, so only that width fits.
    if (PC_WIDTH != rre_pkg::PC_W) begin : g_width_check
        $error("PC_WIDTH must equal the package counter width.");
    end

    // Rotates a byte one place through carry; the top bit is carry out.
    function automatic logic [8:0] rre_rotate(input logic [7:0] data,
                                              input logic carry,
                                              input logic left);
        logic [8:0] out;
        if (left) begin
            out = {data[rre_pkg::MSB_POS], data[6:0], carry};
        end else begin
            out = {data[rre_pkg::LSB_POS], carry, data[7:1]};
        end
        return out;
    endfunction : rre_rotate

    rre_pkg::rre_regs_s q_r;  // Present state.
    rre_pkg::rre_regs_s q_nxt;  // Next state.
    logic [8:0] rot;  // Carry out and rotated byte.
    logic accept;  // An instruction is taken this cycle.

    // An instruction is taken only while no return is in flight.
    assign accept = issue_in.valid && (q_r.state == rre_pkg::st_idle);

    // Works out the next state and the write strobes of the next cycle.
    always_comb begin
        q_nxt = q_r;
        rot = rre_rotate(core_in.reg_data, core_in.carry,
                         issue_in.op == rre_pkg::op_rotate_left_carry);
        // Strobes are single-cycle pulses unless set below.
        q_nxt.res.accumulator_we = 1'h0;
        q_nxt.res.reg_we = 1'h0;
        q_nxt.res.pc_load = 1'h0;
        q_nxt.res.stack_pop = 1'h0;
        q_nxt.res.carry_we = 1'h0;
        case (q_r.state)
            rre_pkg::st_idle: begin
                // Waiting for an instruction.
                if (issue_in.valid) begin
                    case (issue_in.op)
                        rre_pkg::op_subroutine_return,
                        rre_pkg::op_return_with_literal: begin
                            // Returns spend one cycle busy, then pop.
                            q_nxt.state = rre_pkg::st_return;
                            q_nxt.literal = (issue_in.op ==
                                rre_pkg::op_return_with_literal);
                            q_nxt.imm = issue_in.imm;
                            q_nxt.res.busy = 1'h1;
                        end
                        rre_pkg::op_rotate_left_carry,
                        rre_pkg::op_rotate_right_carry: begin
                            // Rotates finish at once and write carry and the selected destination.
                            q_nxt.res.carry_we = 1'h1;
                            q_nxt.res.carry_value = rot[8];
                            if (issue_in.dest == rre_pkg::DEST_REGISTER) begin
                                // Result goes back to the addressed register.
                                q_nxt.res.reg_we = 1'h1;
                                q_nxt.res.reg_addr = issue_in.addr;
                                q_nxt.res.reg_data = rot[7:0];
                            end else begin
                                // Result goes to the accumulator.
                                q_nxt.res.accumulator_we = 1'h1;
                                q_nxt.res.accumulator_data = rot[7:0];
                            end
                        end
                        default: begin
                            // Other codes belong to other units.
                        end
                    endcase
                end
            end
            rre_pkg::st_return: begin
                // Second cycle of a return: load the counter and pop.
                q_nxt.res.pc_load = 1'h1;
                q_nxt.res.pc_value = core_in.stack_top;
                q_nxt.res.stack_pop = 1'h1;
                if (q_r.literal) begin
                    // Literal return also loads the immediate.
                    q_nxt.res.accumulator_we = 1'h1;
                    q_nxt.res.accumulator_data = q_r.imm;
                end
                q_nxt.res.busy = 1'h0;
                q_nxt.state = rre_pkg::st_idle;
            end
            default: begin
                // An illegal state falls back to reset.
                q_nxt = rre_pkg::REGS_RESET;
            end
        endcase
    end

    // Registers all state; the clock enable freezes it.
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            q_r <= rre_pkg::REGS_RESET;
        end else if (clk_en_in) begin
            q_r <= q_nxt;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign result_out = q_r.res;

    // Assertions sample on the core clock and rest while frozen or in reset.
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in || !clk_en_in);

    // A return of the given kind is taken.
    sequence s_return_taken(rre_pkg::rre_op_e kind);
        accept && issue_in.op == kind;
    endsequence

    // The first cycle of a return: busy, nothing written yet.
    sequence s_return_wait;
        result_out.busy && !result_out.pc_load && !result_out.stack_pop;
    endsequence

    // The second cycle of a return: counter loaded and stack popped.
    sequence s_return_done;
        result_out.pc_load && result_out.stack_pop && !result_out.busy;
    endsequence

    // A rotate of either direction is taken.
    sequence s_rotate_taken;
        accept && (issue_in.op == rre_pkg::op_rotate_left_carry ||
                   issue_in.op == rre_pkg::op_rotate_right_carry);
    endsequence

    ret_lit_load_a: assert property (
        s_return_taken(rre_pkg::op_return_with_literal) |-> ##2
        (result_out.accumulator_we &&
         result_out.accumulator_data == $past(issue_in.imm, 2)))
        else $error("Literal return did not load the immediate.");

    ret_lit_pop_a: assert property (
        s_return_taken(rre_pkg::op_return_with_literal) |=>
        s_return_wait ##1 s_return_done)
        else $error("Literal return did not pop in its second cycle.");

    sub_ret_flags_a: assert property (
        s_return_taken(rre_pkg::op_subroutine_return) |=>
        (s_return_wait and !result_out.carry_we) ##1
        (s_return_done and !result_out.carry_we &&
         !result_out.accumulator_we &&
         result_out.pc_value == $past(core_in.stack_top)))
        else $error("Plain return misbehaved.");

    rot_left_a: assert property (
        accept && issue_in.op == rre_pkg::op_rotate_left_carry |=>
        result_out.carry_value == $past(core_in.reg_data[7]) &&
        (result_out.reg_we ? result_out.reg_data :
         result_out.accumulator_data) ==
        {$past(core_in.reg_data[6:0]), $past(core_in.carry)})
        else $error("Left rotate result is wrong.");

    rot_dest_a: assert property (
        s_rotate_taken |=>
        (result_out.reg_we != result_out.accumulator_we) &&
        result_out.reg_we == $past(issue_in.dest) &&
        (!result_out.reg_we || result_out.reg_addr == $past(issue_in.addr)))
        else $error("Rotate result went to the wrong place.");

    rot_right_a: assert property (
        accept && issue_in.op == rre_pkg::op_rotate_right_carry |=>
        result_out.carry_value == $past(core_in.reg_data[0]) &&
        (result_out.reg_we ? result_out.reg_data :
         result_out.accumulator_data) ==
        {$past(core_in.carry), $past(core_in.reg_data[7:1])})
        else $error("Right rotate result is wrong.");

    rot_single_a: assert property (
        s_rotate_taken |=> result_out.carry_we && !result_out.busy &&
        !result_out.pc_load && !result_out.stack_pop)
        else $error("Rotate did not finish in one cycle.");

    pop_pair_a: assert property (
        result_out.stack_pop |-> result_out.pc_load &&
        $past(result_out.busy))
        else $error("Stack popped outside a return.");

    // A busy cycle lasts one cycle and takes no offer.
    busy_refuse_a: assert property (
        result_out.busy |=> !result_out.busy && !result_out.carry_we &&
        !result_out.reg_we)
        else $error("An offer was taken while a return was busy.");

    // A literal return takes the counter from the stack in its busy cycle.
    ret_lit_pc_a: assert property (
        s_return_taken(rre_pkg::op_return_with_literal) |-> ##2
        (result_out.pc_value == $past(core_in.stack_top)))
        else $error("Literal return loaded the wrong counter.");

    // A rotate into the register leaves the accumulator data alone.
    rot_reg_keep_a: assert property (
        s_rotate_taken ##0 (issue_in.dest == rre_pkg::DEST_REGISTER) |=>
        $stable(result_out.accumulator_data))
        else $error("Register rotate disturbed the accumulator data.");

    // A rotate into the accumulator leaves the register fields alone.
    rot_acc_keep_a: assert property (
        s_rotate_taken ##0 (issue_in.dest == rre_pkg::DEST_ACCUMULATOR) |=>
        $stable(result_out.reg_data) && $stable(result_out.reg_addr))
        else $error("Accumulator rotate disturbed the register fields.");

    // A rotate never loads the program counter.
    rot_keep_pc_a: assert property (
        s_rotate_taken |=> $stable(result_out.pc_value))
        else $error("Rotate disturbed the program counter.");

endmodule : rre_exec

`default_nettype wire

// >>> dv/rre_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the return and rotate execution block.
module testbench;
    logic clk_sys_in = 1'b0;  // Core clock, 40 ns period.
    logic sys_rst_in = 1'b1;  // Reset, held high at start.
    logic clk_en_in = 1'b1;  // Clock enable.
    rre_pkg::rre_issue_s issue = '0;  // Offered instruction.
    rre_pkg::rre_core_s core = '0;  // Operands from the core.
    rre_pkg::rre_result_s res;  // Registered results.
    logic [7:0] acc_model = 8'h00;  // Last value sent to the accumulator.
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    rre_exec #(.PC_WIDTH(11)) i_rre_exec (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .issue_in(issue),
        .core_in(core),
        .result_out(res)
    );

    // Clock generator.
    always #20 clk_sys_in = ~clk_sys_in;

    // Cuts a hang short well after the sequence should have ended.
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            final_report();
        end
    end

    // Compares a seen value with the expected one.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops.
    task automatic final_report();
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // Offers one rotate and checks its one-cycle result; valid stays up.
    task automatic rot(input logic left, input logic dest,
                       input logic [6:0] addr, input logic [7:0] data,
                       input logic c);
        logic [7:0] exp_v;
        logic exp_c;
        issue.valid = 1'b1;
        if (left) begin
            issue.op = rre_pkg::op_rotate_left_carry;
            exp_v = {data[6:0], c};
            exp_c = data[7];
        end else begin
            issue.op = rre_pkg::op_rotate_right_carry;
            exp_v = {c, data[7:1]};
            exp_c = data[0];
        end
        issue.addr = addr;
        issue.dest = dest;
        core.reg_data = data;
        core.carry = c;
        @(negedge clk_sys_in);
        check(res.carry_we, 1'b1);
        check(res.carry_value, exp_c);
        check(res.reg_we, dest);
        check(res.accumulator_we, !dest);
        check(res.busy, 1'b0);
        if (dest) begin
            check(res.reg_data, exp_v);
            check(res.reg_addr, addr);
        end else begin
            check(res.accumulator_data, exp_v);
            acc_model = exp_v;
        end
    endtask : rot

    // Drops valid and checks that every strobe falls after one cycle.
    task automatic idle();
        issue.valid = 1'b0;
        @(negedge clk_sys_in);
        check({res.reg_we, res.accumulator_we, res.carry_we, res.pc_load,
               res.stack_pop}, 16'h0000);
    endtask : idle

    // Runs a return; a rotate offered while busy must be ignored.
    task automatic ret(input logic lit, input logic [7:0] imm,
                       input logic [10:0] top);
        issue.valid = 1'b1;
        if (lit) begin
            issue.op = rre_pkg::op_return_with_literal;
        end else begin
            issue.op = rre_pkg::op_subroutine_return;
        end
        issue.imm = imm;
        issue.dest = 1'b1;
        // The stack top only counts in the busy cycle, so offer its inverse.
        core.stack_top = ~top;
        @(negedge clk_sys_in);
        check(res.busy, 1'b1);
        check({res.pc_load, res.stack_pop}, 16'h0000);
        // This offer falls in the busy cycle and has no effect.
        issue.op = rre_pkg::op_rotate_left_carry;
        core.stack_top = top;
        @(negedge clk_sys_in);
        check(res.pc_load, 1'b1);
        check(res.pc_value, top);
        check(res.stack_pop, 1'b1);
        check(res.accumulator_we, lit);
        check({res.carry_we, res.reg_we, res.busy}, 16'h0000);
        if (lit) begin
            acc_model = imm;
        end
        check(res.accumulator_data, acc_model);
        idle();
    endtask : ret

    // Clock enable low freezes a pulse; the empty opcode is then ignored.
    task automatic refuse();
        rot(1'b1, 1'b1, 7'h22, 8'h81, 1'b0);
        clk_en_in = 1'b0;
        issue.op = rre_pkg::op_rotate_right_carry;
        core.reg_data = 8'h00;
        @(negedge clk_sys_in);
        check({res.reg_we, res.reg_data}, {1'b1, 8'h02});
        clk_en_in = 1'b1;
        issue.op = rre_pkg::op_none;
        @(negedge clk_sys_in);
        check({res.reg_we, res.carry_we, res.accumulator_we, res.busy},
              16'h0000);
        idle();
    endtask : refuse

    // A reset in the busy cycle of a return clears every result.
    task automatic reset_mid();
        issue.valid = 1'b1;
        issue.op = rre_pkg::op_subroutine_return;
        core.stack_top = 11'h155;
        @(negedge clk_sys_in);
        check(res.busy, 1'b1);
        issue.valid = 1'b0;
        sys_rst_in = 1'b1;
        @(negedge clk_sys_in);
        check(res, '0);
        sys_rst_in = 1'b0;
        @(negedge clk_sys_in);
        check(res, '0);
        rot(1'b0, 1'b0, 7'h11, 8'h03, 1'b0);
        idle();
    endtask : reset_mid

    // Main sequence.
    initial begin
        repeat (5) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        @(negedge clk_sys_in);
        check(res, '0);
        // Back-to-back rotates over both destinations and address ends.
        rot(1'b1, 1'b1, 7'h7F, 8'hA5, 1'b0);
        rot(1'b0, 1'b1, 7'h00, 8'hA5, 1'b0);
        rot(1'b1, 1'b0, 7'h40, 8'h01, 1'b1);
        rot(1'b0, 1'b0, 7'h05, 8'h80, 1'b1);
        idle();
        refuse();
        ret(1'b1, 8'hFF, 11'h7FF);
        ret(1'b0, 8'h00, 11'h001);
        ret(1'b1, 8'h00, 11'h400);
        reset_mid();
        final_report();
    end
endmodule : testbench

`default_nettype wire
